// ===== include/t16_pkg.sv
// Shared constants, types and mode decoding for the 16-bit timer core.
`default_nettype none

package t16_pkg;

  // ==========================================================================
  // I/O location map (register index on the 8-bit I/O bus).
  localparam int T16_AW = 4;
  localparam logic [3:0] T16_CTRL_A = 4'h0;
  localparam logic [3:0] T16_CTRL_B = 4'h1;
  localparam logic [3:0] T16_CNT_LO = 4'h2;
  localparam logic [3:0] T16_CNT_HI = 4'h3;
  localparam logic [3:0] T16_CMPA_LO = 4'h4;
  localparam logic [3:0] T16_CMPA_HI = 4'h5;
  localparam logic [3:0] T16_CMPB_LO = 4'h6;
  localparam logic [3:0] T16_CMPB_HI = 4'h7;
  localparam logic [3:0] T16_CMPC_LO = 4'h8;
  localparam logic [3:0] T16_CMPC_HI = 4'h9;
  localparam logic [3:0] T16_CAP_LO = 4'hA;
  localparam logic [3:0] T16_CAP_HI = 4'hB;
  localparam logic [3:0] T16_FLAGS = 4'hC;

  // ==========================================================================
  // Field positions and reset values.
  localparam int T16_A_WGM_LSB = 0;
  localparam int T16_B_CS_LSB = 0;
  localparam int T16_B_WGM_LSB = 3;
  localparam int T16_F_OVF = 0;
  localparam logic [7:0] T16_BYTE_RST = 8'h00;
  localparam logic [15:0] T16_WORD_RST = 16'h0000;
  localparam logic [15:0] T16_MAX = 16'hFFFF;
  localparam logic [15:0] T16_BOTTOM = 16'h0000;
  localparam logic [15:0] T16_TOP_8BIT = 16'h00FF;
  localparam logic [15:0] T16_TOP_9BIT = 16'h01FF;
  localparam logic [15:0] T16_TOP_10BIT = 16'h03FF;

  // ==========================================================================
  // Clock source select codes and prescaler masks (divide ratio minus one).
  localparam logic [2:0] T16_CS_NONE = 3'h0;
  localparam logic [2:0] T16_CS_SYS = 3'h1;
  localparam logic [2:0] T16_CS_DIV8 = 3'h2;
  localparam logic [2:0] T16_CS_DIV64 = 3'h3;
  localparam logic [2:0] T16_CS_DIV256 = 3'h4;
  localparam logic [2:0] T16_CS_DIV1024 = 3'h5;
  localparam logic [2:0] T16_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] T16_CS_EXT_RISE = 3'h7;
  localparam int T16_PRE_W = 10;
  localparam logic [9:0] T16_MASK_8 = 10'h007;
  localparam logic [9:0] T16_MASK_64 = 10'h03F;
  localparam logic [9:0] T16_MASK_256 = 10'h0FF;
  localparam logic [9:0] T16_MASK_1024 = 10'h3FF;

  // ==========================================================================
  // Types.
  typedef enum logic {T16_UP, T16_DOWN} t16_dir_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } t16_io_req_t;

  typedef struct packed {
    logic [15:0] cnt;
    t16_dir_t dir;
    logic ovf;
  } t16_step_t;

  // ==========================================================================
  // Mode decoding, used by the core and the step logic.
  function automatic logic t16_dual_slope(input logic [3:0] wgm);
    return (wgm inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11});
  endfunction : t16_dual_slope

  function automatic logic t16_cap_is_top(input logic [3:0] wgm);
    return (wgm inside {4'd8, 4'd10, 4'd12, 4'd14});
  endfunction : t16_cap_is_top

  function automatic logic [15:0] t16_top_of(input logic [3:0] wgm,
                                             input logic [15:0] cmpa,
                                             input logic [15:0] cap);
    unique case (wgm)
      4'd1, 4'd5: return T16_TOP_8BIT;
      4'd2, 4'd6: return T16_TOP_9BIT;
      4'd3, 4'd7: return T16_TOP_10BIT;
      4'd4, 4'd9, 4'd11, 4'd15: return cmpa;
      4'd8, 4'd10, 4'd12, 4'd14: return cap;
      default: return T16_MAX;
    endcase
  endfunction : t16_top_of

endpackage : t16_pkg

`default_nettype wire

// ===== core/t16_tick_select.sv
// Clock source selection: prescaled system ticks or external pin edges.
`default_nettype none

module t16_tick_select (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Selection and external pin.
  input wire logic [2:0] clock_source_select_i,
  input wire logic ext_pin_i,
  // Timer tick enable, one cycle wide.
  output logic timer_tick_o
);
  import t16_pkg::*;

  logic [T16_PRE_W-1:0] pre;
  logic [T16_PRE_W-1:0] next_pre;
  logic pin_prev;
  logic next_tick;

  // ==========================================================================
  // Free running prescaler; it is shared by all divided sources so that a
  // change of ratio does not restart the phase.
  always_comb begin
    next_pre = pre + {{(T16_PRE_W-1){1'b0}}, 1'b1};
    next_tick = 1'b0;
    unique case (clock_source_select_i)
      T16_CS_NONE: next_tick = 1'b0;
      T16_CS_SYS: next_tick = 1'b1;
      T16_CS_DIV8: next_tick = ((pre & T16_MASK_8) == T16_MASK_8);
      T16_CS_DIV64: next_tick = ((pre & T16_MASK_64) == T16_MASK_64);
      T16_CS_DIV256: next_tick = ((pre & T16_MASK_256) == T16_MASK_256);
      T16_CS_DIV1024: next_tick = (pre == T16_MASK_1024);
      T16_CS_EXT_FALL: next_tick = pin_prev & ~ext_pin_i;
      T16_CS_EXT_RISE: next_tick = ~pin_prev & ext_pin_i;
    endcase
  end

  // Register the prescaler, the pin history and the tick.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pre <= '0;
      pin_prev <= 1'b0;
      timer_tick_o <= 1'b0;
    end else begin
      pre <= next_pre;
      pin_prev <= ext_pin_i;
      timer_tick_o <= next_tick;
    end
  end

endmodule : t16_tick_select

`default_nettype wire

// ===== core/t16_count_step.sv
// One counting step of the bidirectional counter for the current mode.
`default_nettype none

module t16_count_step (
  // Present counter state.
  input wire logic [15:0] cnt_i,
  input wire t16_pkg::t16_dir_t dir_i,
  // Mode and sequence maximum.
  input wire logic [3:0] wgm_i,
  input wire logic [15:0] top_i,
  // Result of one tick.
  output t16_pkg::t16_step_t step_o
);
  import t16_pkg::*;

  // ==========================================================================
  // Dual slope modes turn at TOP and BOTTOM and flag overflow at BOTTOM.
  // Single slope modes clear after TOP; the >= guards against a TOP lowered
  // below the count, which would otherwise run round the whole range.
  always_comb begin
    step_o.cnt = cnt_i;
    step_o.dir = dir_i;
    step_o.ovf = 1'b0;
    if (t16_dual_slope(wgm_i)) begin
      step_o.ovf = (cnt_i == T16_BOTTOM);
      if (dir_i == T16_UP) begin
        if (cnt_i >= top_i) begin
          step_o.dir = T16_DOWN;
          step_o.cnt = cnt_i - 16'h0001;
        end else begin
          step_o.cnt = cnt_i + 16'h0001;
        end
      end else if (cnt_i == T16_BOTTOM) begin
        step_o.dir = T16_UP;
        step_o.cnt = cnt_i + 16'h0001;
      end else begin
        step_o.cnt = cnt_i - 16'h0001;
      end
    end else begin
      step_o.dir = T16_UP;
      // Clear-on-compare modes still flag overflow only at MAX.
      if (wgm_i == 4'd4 || wgm_i == 4'd12) begin
        step_o.ovf = (cnt_i == T16_MAX);
      end else begin
        step_o.ovf = (cnt_i >= top_i);
      end
      step_o.cnt = (cnt_i >= top_i) ? T16_BOTTOM : cnt_i + 16'h0001;
    end
  end

endmodule : t16_count_step

`default_nettype wire

// ===== core/t16_timer_core.sv
// 16-bit timer/counter with byte-wide CPU access through a shared latch.
`default_nettype none

module t16_timer_core (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic resetn_i,
  // CPU I/O access, one request per cycle; write and read strobes may both be set.
  input wire t16_pkg::t16_io_req_t io_req_i,
  output logic [7:0] io_rdata_o,
  // External tick pin, synchronous to mclk_i.
  input wire logic ext_pin_i,
  // Counter state for the waveform and capture logic.
  output logic [15:0] timer_count_value_o,
  output logic top_o,
  output logic bottom_o,
  output logic overflow_flag_o
);
  import t16_pkg::*;

  // ==========================================================================
  // Register file state.
  logic [7:0] hi_latch; // Shared by every 16-bit register.
  logic [7:0] next_hi_latch;
  logic [1:0] wgm_lo;
  logic [1:0] next_wgm_lo;
  logic [1:0] wgm_hi;
  logic [1:0] next_wgm_hi;
  logic [2:0] clock_source_select;
  logic [2:0] next_clock_source_select;
  logic [15:0] cmp_a;
  logic [15:0] next_cmp_a;
  logic [15:0] cmp_b;
  logic [15:0] next_cmp_b;
  logic [15:0] cmp_c;
  logic [15:0] next_cmp_c;
  logic [15:0] cap;
  logic [15:0] next_cap;
  logic [7:0] next_rdata;

  // ==========================================================================
  // Counter state.
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  t16_dir_t dir;
  t16_dir_t next_dir;
  logic next_top;
  logic next_bottom;
  logic next_ovf;

  // ==========================================================================
  // Decoded access strobes and mode.
  logic wr_en;
  logic rd_en;
  logic [7:0] wdata;
  logic cnt_lo_wr;
  logic [3:0] wgm;
  logic [15:0] top_val;
  logic timer_tick;
  t16_step_t step;

  assign wr_en = io_req_i.wr;
  assign rd_en = io_req_i.rd;
  assign wdata = io_req_i.wdata;
  assign cnt_lo_wr = wr_en && (io_req_i.addr == T16_CNT_LO);
  assign wgm = {wgm_hi, wgm_lo}; // Split over both control registers.
  assign top_val = t16_top_of(wgm, cmp_a, cap);

  // ==========================================================================
  // Tick source. A select of zero yields no tick at all, so the counter
  // simply holds while CPU access keeps working.
  t16_tick_select u_tick (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .clock_source_select_i(clock_source_select),
    .ext_pin_i(ext_pin_i),
    .timer_tick_o(timer_tick)
  );

  // One counting step for the current mode.
  t16_count_step u_step (
    .cnt_i(cnt),
    .dir_i(dir),
    .wgm_i(wgm),
    .top_i(top_val),
    .step_o(step)
  );

  // ==========================================================================
  // Register file next values. A write and a read may come in the same
  // cycle; both are honoured, on the single address of the request.
  always_comb begin
    next_hi_latch = hi_latch;
    next_wgm_lo = wgm_lo;
    next_wgm_hi = wgm_hi;
    next_clock_source_select = clock_source_select;
    next_cmp_a = cmp_a;
    next_cmp_b = cmp_b;
    next_cmp_c = cmp_c;
    next_cap = cap;
    next_rdata = io_rdata_o;

    // Writes. Every high location only loads the latch; the low location
    // commits latch plus byte. The latch is left as it was, so one high
    // write can serve several low writes.
    if (wr_en) begin
      unique case (io_req_i.addr)
        T16_CTRL_A: next_wgm_lo = wdata[T16_A_WGM_LSB +: 2];
        T16_CTRL_B: begin
          next_clock_source_select = wdata[T16_B_CS_LSB +: 3];
          next_wgm_hi = wdata[T16_B_WGM_LSB +: 2];
        end
        T16_CNT_HI, T16_CMPA_HI, T16_CMPB_HI, T16_CMPC_HI, T16_CAP_HI: begin
          next_hi_latch = wdata;
        end
        T16_CMPA_LO: next_cmp_a = {hi_latch, wdata};
        T16_CMPB_LO: next_cmp_b = {hi_latch, wdata};
        T16_CMPC_LO: next_cmp_c = {hi_latch, wdata};
        T16_CAP_LO: begin
          // The capture value is only writable while it defines TOP.
          if (t16_cap_is_top(wgm)) begin
            next_cap = {hi_latch, wdata};
          end
        end
        default: begin
        end
      endcase
    end

    // Reads. Low reads of latched registers snapshot the high byte into
    // the latch in the same cycle; compare reads return bytes directly.
    if (rd_en) begin
      unique case (io_req_i.addr)
        T16_CTRL_A: next_rdata = {6'h00, wgm_lo};
        T16_CTRL_B: next_rdata = {3'h0, wgm_hi, clock_source_select};
        T16_CNT_LO: begin
          next_rdata = cnt[7:0];
          next_hi_latch = cnt[15:8];
        end
        T16_CNT_HI: next_rdata = hi_latch;
        T16_CAP_LO: begin
          next_rdata = cap[7:0];
          next_hi_latch = cap[15:8];
        end
        T16_CAP_HI: next_rdata = hi_latch;
        T16_CMPA_LO: next_rdata = cmp_a[7:0];
        T16_CMPA_HI: next_rdata = cmp_a[15:8];
        T16_CMPB_LO: next_rdata = cmp_b[7:0];
        T16_CMPB_HI: next_rdata = cmp_b[15:8];
        T16_CMPC_LO: next_rdata = cmp_c[7:0];
        T16_CMPC_HI: next_rdata = cmp_c[15:8];
        T16_FLAGS: next_rdata = {7'h00, overflow_flag_o};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Register file flip-flops.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      hi_latch <= T16_BYTE_RST;
      wgm_lo <= 2'b00;
      wgm_hi <= 2'b00;
      clock_source_select <= T16_CS_NONE;
      cmp_a <= T16_WORD_RST;
      cmp_b <= T16_WORD_RST;
      cmp_c <= T16_WORD_RST;
      cap <= T16_WORD_RST;
      io_rdata_o <= T16_BYTE_RST;
    end else begin
      hi_latch <= next_hi_latch;
      wgm_lo <= next_wgm_lo;
      wgm_hi <= next_wgm_hi;
      clock_source_select <= next_clock_source_select;
      cmp_a <= next_cmp_a;
      cmp_b <= next_cmp_b;
      cmp_c <= next_cmp_c;
      cap <= next_cap;
      io_rdata_o <= next_rdata;
    end
  end

  // ==========================================================================
  // Counter next values. A tick applies the mode's step; without one the
  // value holds. A CPU low-byte write replaces the count the step would
  // have made, though the step's direction change still applies; the overflow
  // that step would have raised is dropped, because that count never took place.
  always_comb begin
    next_cnt = cnt;
    next_dir = dir;
    next_ovf = overflow_flag_o;
    if (timer_tick) begin
      next_cnt = step.cnt;
      next_dir = step.dir;
    end
    if (cnt_lo_wr) begin
      next_cnt = {hi_latch, wdata};
    end
    // Writing one clears the flag, but a new overflow in the same cycle
    // wins so that no event is lost.
    if (wr_en && io_req_i.addr == T16_FLAGS && wdata[T16_F_OVF]) begin
      next_ovf = 1'b0;
    end
    if (timer_tick && step.ovf && !cnt_lo_wr) begin
      next_ovf = 1'b1;
    end
    // Indications follow the value the counter is about to hold.
    next_top = (next_cnt == top_val);
    next_bottom = (next_cnt == T16_BOTTOM);
  end

  // Counter flip-flops; every top-level output comes from here or above.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cnt <= T16_WORD_RST;
      dir <= T16_UP;
      top_o <= 1'b0;
      bottom_o <= 1'b1;
      overflow_flag_o <= 1'b0;
      timer_count_value_o <= T16_WORD_RST;
    end else begin
      cnt <= next_cnt;
      dir <= next_dir;
      top_o <= next_top;
      bottom_o <= next_bottom;
      overflow_flag_o <= next_ovf;
      timer_count_value_o <= next_cnt;
    end
  end

endmodule : t16_timer_core

`default_nettype wire

// ===== verif/t16_monitor.sv
// Port checker for the 16-bit timer core, bound to every core instance.
`default_nettype none

module t16_monitor (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic resetn_i,
  // CPU access and core outputs.
  input wire t16_pkg::t16_io_req_t io_req_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic ext_pin_i,
  input wire logic [15:0] timer_count_value_o,
  input wire logic top_o,
  input wire logic bottom_o,
  input wire logic overflow_flag_o
);
  import t16_pkg::*;

  // ==========================================================================
  // Helper copies of select and mode; the tick may lag a select change.
  logic [2:0] cs_q;
  logic [2:0] cs_d1;
  logic [2:0] cs_d2;
  logic [3:0] wgm_q;
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cs_q <= T16_CS_NONE;
      wgm_q <= 4'h0;
    end else if (io_req_i.wr && io_req_i.addr == T16_CTRL_B) begin
      cs_q <= io_req_i.wdata[2:0];
      wgm_q[3:2] <= io_req_i.wdata[4:3];
    end else if (io_req_i.wr && io_req_i.addr == T16_CTRL_A) begin
      wgm_q[1:0] <= io_req_i.wdata[1:0];
    end
    cs_d1 <= resetn_i ? cs_q : T16_CS_NONE;
    cs_d2 <= resetn_i ? cs_d1 : T16_CS_NONE;
  end

  // Decoded strokes and settled running conditions.
  logic w_clo, w_chi, w_alo, w_ahi, r_clo, r_chi, r_ahi, run1, stop;
  logic [7:0] cnt_hi_b;
  logic [7:0] cnt_lo_b;
  assign w_clo = io_req_i.wr && io_req_i.addr == T16_CNT_LO;
  assign w_chi = io_req_i.wr && io_req_i.addr == T16_CNT_HI;
  assign w_alo = io_req_i.wr && io_req_i.addr == T16_CMPA_LO;
  assign w_ahi = io_req_i.wr && io_req_i.addr == T16_CMPA_HI;
  assign r_clo = io_req_i.rd && io_req_i.addr == T16_CNT_LO;
  assign r_chi = io_req_i.rd && io_req_i.addr == T16_CNT_HI;
  assign r_ahi = io_req_i.rd && io_req_i.addr == T16_CMPA_HI;
  assign run1 = cs_q == T16_CS_SYS && cs_d1 == T16_CS_SYS && cs_d2 == T16_CS_SYS && wgm_q == 4'h0;
  assign stop = cs_q == T16_CS_NONE && cs_d1 == T16_CS_NONE && cs_d2 == T16_CS_NONE;
  assign cnt_hi_b = timer_count_value_o[15:8];
  assign cnt_lo_b = timer_count_value_o[7:0];

  // ==========================================================================
  // Assertions.
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_snap;
    r_clo ##1 r_chi;
  endsequence
  sequence s_cmp_wr;
    w_ahi ##1 w_alo;
  endsequence

  chk_bottom_zero: assert property (bottom_o == (timer_count_value_o == T16_BOTTOM))
    else $error("bottom flag disagrees with count");
  chk_top_max: assert property (wgm_q == 4'h0 && $past(wgm_q) == 4'h0 |->
    top_o == (timer_count_value_o == T16_MAX)) else $error("top flag wrong in mode 0");
  chk_count_commit: assert property (w_clo && $past(w_chi) |=>
    timer_count_value_o == {$past(io_req_i.wdata, 2), $past(io_req_i.wdata)})
    else $error("count low write did not commit latch and byte");
  chk_stop_hold: assert property (stop && !w_clo |=> $stable(timer_count_value_o))
    else $error("count moved with no source");
  chk_count_step: assert property (run1 && !w_clo |=>
    timer_count_value_o == $past(timer_count_value_o) + 16'h0001) else $error("bad count step");
  chk_ovf_set: assert property (run1 && !w_clo && timer_count_value_o == T16_MAX |=>
    overflow_flag_o) else $error("overflow not flagged");
  chk_low_read: assert property (r_clo |=> io_rdata_o == $past(cnt_lo_b))
    else $error("count low read wrong");
  chk_latch_read: assert property (s_snap |=> io_rdata_o == $past(cnt_hi_b, 2))
    else $error("count high read not from snapshot");
  chk_cmp_direct: assert property (s_cmp_wr ##1 w_chi ##1 r_ahi |=>
    io_rdata_o == $past(io_req_i.wdata, 4)) else $error("compare read used the latch");
  chk_latch_reuse: assert property (w_chi ##1 w_alo ##1 w_clo |=>
    timer_count_value_o == {$past(io_req_i.wdata, 3), $past(io_req_i.wdata)})
    else $error("latch lost after low write");
endmodule : t16_monitor

bind t16_timer_core t16_monitor mon_u (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .io_req_i(io_req_i), .io_rdata_o(io_rdata_o), .ext_pin_i(ext_pin_i),
  .timer_count_value_o(timer_count_value_o), .top_o(top_o), .bottom_o(bottom_o),
  .overflow_flag_o(overflow_flag_o));

`default_nettype wire

// ===== verif/t16_cpu_model.sv
// Behavioural CPU that drives the byte-wide I/O bus of the timer core.
`default_nettype none

module t16_cpu_model (
  // Clock.
  input wire logic mclk_i,
  // Bus request and read data.
  output var t16_pkg::t16_io_req_t io_req_o,
  input wire logic [7:0] io_rdata_i
);
  timeunit 1ns;
  timeprecision 100ps;
  import t16_pkg::*;

  // Bus starts quiet.
  initial begin
    io_req_o = '0;
  end

  // One request held for exactly one edge, changed 1 ns after it.
  task automatic cycle(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
    io_req_o = '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge mclk_i);
    #1;
  endtask : cycle

  // Released bus: strobes low, address and data flip so stale values never match.
  task automatic idle();
    io_req_o = '{addr: ~io_req_o.addr, wdata: ~io_req_o.wdata, wr: 1'b0, rd: 1'b0};
    @(posedge mclk_i);
    #1;
  endtask : idle

  // Two-byte write, high byte first; one process, so nothing can interleave.
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    cycle(lo + 4'h1, v[15:8], 1'b1, 1'b0);
    cycle(lo, v[7:0], 1'b1, 1'b0);
    idle();
  endtask : wr16

  // Two-byte read, low byte first so the high byte comes from the snapshot.
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    cycle(lo, 8'h00, 1'b0, 1'b1);
    v[7:0] = io_rdata_i;
    cycle(lo + 4'h1, 8'h00, 1'b0, 1'b1);
    v[15:8] = io_rdata_i;
    idle();
  endtask : rd16
endmodule : t16_cpu_model

`default_nettype wire

// ===== verif/tb.sv
// Self-checking testbench for the 16-bit timer core.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import t16_pkg::*;

  // ==========================================================================
  // Signals and instances.
  logic mclk_i, resetn_i, ext_pin_i, top, bottom, ovf;
  t16_io_req_t io_req;
  logic [7:0] io_rdata;
  logic [15:0] cnt;
  logic [15:0] v;
  int failures = 0;
  int num_checks = 0;

  t16_cpu_model cpu_u (.mclk_i(mclk_i), .io_req_o(io_req), .io_rdata_i(io_rdata));
  t16_timer_core dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .io_req_i(io_req),
    .io_rdata_o(io_rdata), .ext_pin_i(ext_pin_i), .timer_count_value_o(cnt),
    .top_o(top), .bottom_o(bottom), .overflow_flag_o(ovf));

  // 20 MHz system clock.
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // ==========================================================================
  // Compare and verdict.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    check(cnt, 16'h0000);
    check(bottom, 1'b1);
    check(top, 1'b0);
    check(ovf, 1'b0);
    cpu_u.rd16(T16_CNT_LO, v);
    check(v, 16'h0000);
    $display("t_reset done");
  endtask : t_reset

  // Stopped counter: writes, reads, latch sharing and compare bypass.
  task automatic t_latch();
    cpu_u.wr16(T16_CNT_LO, 16'h01ff);
    repeat (5) cpu_u.idle();
    check(cnt, 16'h01ff);
    cpu_u.rd16(T16_CNT_LO, v);
    check(v, 16'h01ff);
    cpu_u.cycle(T16_CMPA_HI, 8'h12, 1'b1, 1'b0);
    cpu_u.cycle(T16_CMPA_LO, 8'h34, 1'b1, 1'b0);
    cpu_u.cycle(T16_CNT_HI, 8'h77, 1'b1, 1'b0);
    check(cnt, 16'h01ff);
    cpu_u.cycle(T16_CMPA_HI, 8'h00, 1'b0, 1'b1);
    check(io_rdata, 8'h12);
    cpu_u.cycle(T16_CMPA_LO, 8'h01, 1'b1, 1'b0);
    cpu_u.cycle(T16_CNT_LO, 8'h02, 1'b1, 1'b0);
    check(cnt, 16'h7702);
    cpu_u.idle();
    cpu_u.rd16(T16_CMPA_LO, v);
    check(v, 16'h7701);
    // One high write serves a compare low write and then the count low write.
    cpu_u.cycle(T16_CNT_HI, 8'h55, 1'b1, 1'b0);
    cpu_u.cycle(T16_CMPA_LO, 8'h66, 1'b1, 1'b0);
    cpu_u.cycle(T16_CNT_LO, 8'h88, 1'b1, 1'b0);
    check(cnt, 16'h5588);
    cpu_u.idle();
    cpu_u.rd16(T16_CMPA_LO, v);
    check(v, 16'h5566);
    $display("t_latch done");
  endtask : t_latch

  // Every-cycle ticks: wrap, overflow, write priority and flag clear.
  task automatic t_count();
    cpu_u.wr16(T16_CNT_LO, 16'hfffd);
    cpu_u.cycle(T16_CTRL_B, 8'h01, 1'b1, 1'b0);
    for (int i = 0; i < 10 && ovf !== 1'b1; i++) begin
      if (cnt === 16'hffff) check(top, 1'b1);
      cpu_u.idle();
    end
    check(ovf, 1'b1);
    check(cnt, 16'h0000);
    check(bottom, 1'b1);
    cpu_u.wr16(T16_CNT_LO, 16'h0100);
    check(cnt, 16'h0101);
    cpu_u.cycle(T16_FLAGS, 8'h01, 1'b1, 1'b0);
    cpu_u.idle();
    check(ovf, 1'b0);
    cpu_u.cycle(T16_CTRL_B, 8'h00, 1'b1, 1'b0);
    cpu_u.idle();
    $display("t_count done");
  endtask : t_count

  // Dual-slope mode with an 8-bit top turns round at the top.
  task automatic t_dual();
    cpu_u.cycle(T16_CTRL_A, 8'h01, 1'b1, 1'b0);
    cpu_u.wr16(T16_CNT_LO, 16'h00fd);
    cpu_u.cycle(T16_CTRL_B, 8'h01, 1'b1, 1'b0);
    for (int i = 0; i < 10 && cnt !== 16'h00ff; i++) cpu_u.idle();
    check(top, 1'b1);
    cpu_u.idle();
    cpu_u.idle();
    check(cnt, 16'h00fd);
    cpu_u.cycle(T16_CTRL_B, 8'h00, 1'b1, 1'b0);
    cpu_u.cycle(T16_CTRL_A, 8'h00, 1'b1, 1'b0);
    cpu_u.idle();
    $display("t_dual done");
  endtask : t_dual

  // External rising edges as the tick source.
  task automatic t_ext();
    cpu_u.wr16(T16_CNT_LO, 16'h0000);
    cpu_u.cycle(T16_CTRL_B, 8'h07, 1'b1, 1'b0);
    repeat (3) begin
      ext_pin_i = 1'b1;
      repeat (3) cpu_u.idle();
      ext_pin_i = 1'b0;
      repeat (3) cpu_u.idle();
    end
    check(cnt, 16'h0003);
    cpu_u.cycle(T16_CTRL_B, 8'h00, 1'b1, 1'b0);
    cpu_u.idle();
    $display("t_ext done");
  endtask : t_ext

  // ==========================================================================
  // Main sequence and watchdog.
  initial begin
    resetn_i = 1'b0;
    ext_pin_i = 1'b0;
    repeat (16) @(posedge mclk_i);
    #1;
    resetn_i = 1'b1;
    cpu_u.idle();
    t_reset();
    t_latch();
    t_count();
    t_dual();
    t_ext();
    print_verdict();
  end

  // Tests need well under 200 cycles; 2000 means a hang.
  initial begin
    #100000;
    check(16'h0000, 16'h0001);
    print_verdict();
  end
endmodule : tb

`default_nettype wire
